// file: hdl/timer_control_update_regs.sv
// How it works
// - Split enable makes two 8-bit timers and switches the register layout.
// - Clear views at 0x04 and 0x06 clear bits written as one.
// - Set views at 0x05 and 0x07 set bits written as one.
// - Command 1 forces update, 2 restart, 3 hard reset, 0 nothing.
// - Hard reset command is ignored while the timer is enabled.
// - Command field always reads back as zero in both views.
// - Unlocked, buffers transfer to active registers on each update condition.
// - Locked, no transfer happens and buffers keep their contents.
// - Direction bit zero counts up, one counts down; views change it.
// - Hardware also drives direction from waveform mode or event action.
// - Writing a compare buffer sets that channel's valid flag, except in split mode.
// - Writing the period buffer sets the period valid flag, except in split mode.
// - A transfer clears all buffer valid flags except those set or written in the same cycle.
// - Event action picks rising edge, any edge, high level or up/down.
// - Auto lock holds lock until all enabled compare buffers are valid.
// - Update at top counting up in normal/frequency, bottom in PWM modes.
module timer_control_update_regs #(
  parameter int NUM_CMP = timer_ctrl_pkg::NUM_CMP
) (
  input  wire logic                            clock_i,
  input  wire logic                            rst_i,
  input  wire timer_ctrl_pkg::bus_req_t        bus_i,
  input  wire timer_ctrl_pkg::counter_status_t status_i,
  input  wire logic                            period_buffer_write_i,
  input  wire logic [NUM_CMP-1:0]              compare_buffer_write_i,
  output logic [7:0]                           rdata_o,
  output logic                                 enable_o,
  output logic                                 split_mode_enable_o,
  output logic [2:0]                           waveform_mode_select_o,
  output logic                                 count_down_o,
  output logic                                 restart_o,
  output logic                                 hard_reset_o,
  output logic                                 transfer_o,
  output logic                                 update_lock_o,
  output logic                                 count_tick_o
);

  typedef struct packed {
    logic               enable;
    logic [NUM_CMP-1:0] cmp_enable;
    logic               auto_update_lock;
    logic [2:0]         wave;
    logic               split;
    logic               dir;
    logic [2:0]         event_action_select;
    logic               count_on_event_enable;
    logic               event_prev;
    logic               restart;
    logic               hard_reset;
    logic               count_tick;
    logic [7:0]         rdata;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t n;

  logic                     wr_enable;
  logic                     wr_mode;
  logic                     wr_split;
  logic                     wr_e_clr;
  logic                     wr_e_set;
  logic                     wr_bv_clr;
  logic                     wr_bv_set;
  logic                     wr_event;
  timer_ctrl_pkg::command_t cmd;
  logic                     force_update;
  logic                     do_restart;
  logic                     do_hard_reset;
  logic                     natural_update;
  logic                     update_event;
  logic                     dual_slope;
  logic                     lock_q;
  logic [NUM_CMP:0]         bv_q;
  logic [NUM_CMP:0]         buffer_write;
  logic [NUM_CMP:0]         bv_set;
  logic [NUM_CMP:0]         bv_clear;
  logic                     lock_set;
  logic                     lock_clear;
  logic [7:0]               e_view;
  logic [7:0]               bv_view;

  // Bus decode
  always_comb begin
    wr_enable = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_ENABLE_CTRL);
    wr_mode   = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_MODE_CTRL);
    wr_split  = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_SPLIT_CTRL);
    wr_e_clr  = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_CTRL_E_CLR);
    wr_e_set  = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_CTRL_E_SET);
    wr_bv_clr = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_BV_CLR);
    wr_bv_set = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_BV_SET);
    wr_event  = bus_i.wr && (bus_i.addr == timer_ctrl_pkg::OFF_EVENT_CTRL);
  end

  always_comb begin
    cmd = timer_ctrl_pkg::CMD_NONE;
    if (wr_e_clr || wr_e_set) begin
      cmd = timer_ctrl_pkg::command_t'(bus_i.wdata[timer_ctrl_pkg::CMD_LSB +: 2]);
    end
    force_update = 1'b0;
    do_restart = 1'b0;
    do_hard_reset = 1'b0;
    case (cmd)
      timer_ctrl_pkg::CMD_NONE: begin
        force_update = 1'b0;
      end
      timer_ctrl_pkg::CMD_UPDATE: begin
        force_update = 1'b1;
      end
      timer_ctrl_pkg::CMD_RESTART: begin
        do_restart = 1'b1;
      end
      timer_ctrl_pkg::CMD_HARD_RESET: begin
        do_hard_reset = ~s.enable;
      end
      default: begin
        force_update = 1'b0;
      end
    endcase
  end

  always_comb begin
    natural_update = 1'b0;
    dual_slope = 1'b0;
    case (s.wave)
      timer_ctrl_pkg::WAVE_NORMAL,
      timer_ctrl_pkg::WAVE_FREQ: begin
        natural_update = status_i.at_top & ~s.dir;
      end
      timer_ctrl_pkg::WAVE_SINGLE: begin
        natural_update = status_i.at_bottom;
      end
      timer_ctrl_pkg::WAVE_DS_TOP,
      timer_ctrl_pkg::WAVE_DS_BOTH,
      timer_ctrl_pkg::WAVE_DS_BOTTOM: begin
        natural_update = status_i.at_bottom;
        dual_slope = 1'b1;
      end
      default: begin
        natural_update = 1'b0;
      end
    endcase
    update_event = natural_update | force_update;
  end

  // Buffer valid and lock steering
  always_comb begin
    buffer_write = {compare_buffer_write_i, period_buffer_write_i} & {(NUM_CMP+1){~s.split}};
    bv_clear = wr_bv_clr ? bus_i.wdata[NUM_CMP:0] : '0;
    bv_set = wr_bv_set ? bus_i.wdata[NUM_CMP:0] : '0;
    lock_clear = wr_e_clr & bus_i.wdata[timer_ctrl_pkg::LOCK_BIT];
    lock_set = wr_e_set & bus_i.wdata[timer_ctrl_pkg::LOCK_BIT];
  end

  update_lock_ctrl #(
    .NUM_CMP (NUM_CMP)
  ) u_lock (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .hard_reset_i   (do_hard_reset),
    .update_event_i (update_event),
    .auto_lock_i    (s.auto_update_lock),
    .cmp_enable_i   (s.cmp_enable),
    .lock_set_i     (lock_set),
    .lock_clear_i   (lock_clear),
    .bv_set_i       (bv_set),
    .bv_clear_i     (bv_clear),
    .buffer_write_i (buffer_write),
    .update_lock_o  (lock_q),
    .buffer_valid_o (bv_q),
    .transfer_o     (transfer_o)
  );

  always_comb begin
    e_view = timer_ctrl_pkg::RESET_BYTE;
    e_view[timer_ctrl_pkg::DIR_BIT] = s.dir;
    e_view[timer_ctrl_pkg::LOCK_BIT] = lock_q;
    bv_view = timer_ctrl_pkg::RESET_BYTE;
    if (!s.split) begin
      bv_view[NUM_CMP:0] = bv_q;
    end
  end

  always_comb begin
    n = s;
    n.restart = do_restart;
    n.hard_reset = do_hard_reset;
    n.event_prev = status_i.event_level;

    if (wr_enable) begin
      n.enable = bus_i.wdata[timer_ctrl_pkg::ENABLE_BIT];
    end
    if (wr_mode) begin
      n.wave = bus_i.wdata[timer_ctrl_pkg::WAVE_LSB +: 3];
      n.auto_update_lock = bus_i.wdata[timer_ctrl_pkg::AUTO_LOCK_BIT];
      n.cmp_enable = bus_i.wdata[timer_ctrl_pkg::CMP_EN_LSB +: NUM_CMP];
    end
    if (wr_split) begin
      n.split = bus_i.wdata[timer_ctrl_pkg::SPLIT_BIT];
    end
    if (wr_event) begin
      n.count_on_event_enable = bus_i.wdata[timer_ctrl_pkg::EV_ENABLE_BIT];
      n.event_action_select = bus_i.wdata[timer_ctrl_pkg::EV_ACT_LSB +: 3];
    end

    if (dual_slope && status_i.at_top) begin
      n.dir = 1'b1;
    end else if (dual_slope && status_i.at_bottom) begin
      n.dir = 1'b0;
    end
    if (s.count_on_event_enable && (s.event_action_select == timer_ctrl_pkg::EV_UPDOWN)) begin
      n.dir = status_i.event_level;
    end
    // Software direction writes win over hardware
    if (wr_e_clr && bus_i.wdata[timer_ctrl_pkg::DIR_BIT]) begin
      n.dir = 1'b0;
    end
    if (wr_e_set && bus_i.wdata[timer_ctrl_pkg::DIR_BIT]) begin
      n.dir = 1'b1;
    end
    if (do_restart) begin
      n.dir = 1'b0;
    end

    n.count_tick = 1'b0;
    if (!s.enable) begin
      n.count_tick = 1'b0;
    end else if (!s.count_on_event_enable) begin
      n.count_tick = status_i.prescale_tick;
    end else begin
      case (timer_ctrl_pkg::event_action_t'(s.event_action_select))
        timer_ctrl_pkg::EV_RISING: begin
          n.count_tick = status_i.event_level & ~s.event_prev;
        end
        timer_ctrl_pkg::EV_ANY: begin
          n.count_tick = status_i.event_level ^ s.event_prev;
        end
        timer_ctrl_pkg::EV_HIGH: begin
          n.count_tick = status_i.prescale_tick & status_i.event_level;
        end
        timer_ctrl_pkg::EV_UPDOWN: begin
          n.count_tick = status_i.prescale_tick;
        end
        default: begin
          // Reserved actions stall the counter
          n.count_tick = 1'b0;
        end
      endcase
    end

    // Read data lands one cycle after the strobe; unmapped reads give zero
    n.rdata = timer_ctrl_pkg::RESET_BYTE;
    if (bus_i.rd) begin
      case (bus_i.addr)
        timer_ctrl_pkg::OFF_ENABLE_CTRL: begin
          n.rdata[timer_ctrl_pkg::ENABLE_BIT] = s.enable;
        end
        timer_ctrl_pkg::OFF_MODE_CTRL: begin
          n.rdata[timer_ctrl_pkg::WAVE_LSB +: 3] = s.wave;
          n.rdata[timer_ctrl_pkg::AUTO_LOCK_BIT] = s.auto_update_lock;
          n.rdata[timer_ctrl_pkg::CMP_EN_LSB +: NUM_CMP] = s.cmp_enable;
        end
        timer_ctrl_pkg::OFF_SPLIT_CTRL: begin
          n.rdata[timer_ctrl_pkg::SPLIT_BIT] = s.split;
        end
        timer_ctrl_pkg::OFF_CTRL_E_CLR,
        timer_ctrl_pkg::OFF_CTRL_E_SET: begin
          n.rdata = e_view;
        end
        timer_ctrl_pkg::OFF_BV_CLR,
        timer_ctrl_pkg::OFF_BV_SET: begin
          n.rdata = bv_view;
        end
        timer_ctrl_pkg::OFF_EVENT_CTRL: begin
          n.rdata[timer_ctrl_pkg::EV_ENABLE_BIT] = s.count_on_event_enable;
          n.rdata[timer_ctrl_pkg::EV_ACT_LSB +: 3] = s.event_action_select;
        end
        default: begin
          n.rdata = timer_ctrl_pkg::RESET_BYTE;
        end
      endcase
    end

    // Hard reset returns every register to its reset value
    if (do_hard_reset) begin
      n.cmp_enable = '0;
      n.auto_update_lock = 1'b0;
      n.wave = timer_ctrl_pkg::RESET_WAVE;
      n.split = 1'b0;
      n.dir = 1'b0;
      n.event_action_select = timer_ctrl_pkg::RESET_EVENT_ACTION_SELECT;
      n.count_on_event_enable = 1'b0;
      n.count_tick = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    rdata_o = s.rdata;
    enable_o = s.enable;
    split_mode_enable_o = s.split;
    waveform_mode_select_o = s.wave;
    count_down_o = s.dir;
    restart_o = s.restart;
    hard_reset_o = s.hard_reset;
    update_lock_o = lock_q;
    count_tick_o = s.count_tick;
  end

endmodule

// file: hdl/timer_ctrl_pkg.sv
package timer_ctrl_pkg;

  localparam int NUM_CMP = 3;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;

  // Register offsets
  localparam logic [7:0] OFF_ENABLE_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE_CTRL   = 8'h01;
  localparam logic [7:0] OFF_SPLIT_CTRL  = 8'h03;
  localparam logic [7:0] OFF_CTRL_E_CLR  = 8'h04;
  localparam logic [7:0] OFF_CTRL_E_SET  = 8'h05;
  localparam logic [7:0] OFF_BV_CLR      = 8'h06;
  localparam logic [7:0] OFF_BV_SET      = 8'h07;
  localparam logic [7:0] OFF_EVENT_CTRL  = 8'h09;

  // Field positions
  localparam int ENABLE_BIT    = 0;
  localparam int WAVE_LSB      = 0;
  localparam int AUTO_LOCK_BIT = 3;
  localparam int CMP_EN_LSB    = 4;
  localparam int SPLIT_BIT     = 0;
  localparam int DIR_BIT       = 0;
  localparam int LOCK_BIT      = 1;
  localparam int CMD_LSB       = 2;
  localparam int PER_BV_BIT    = 0;
  localparam int CMP_BV_LSB    = 1;
  localparam int EV_ENABLE_BIT = 0;
  localparam int EV_ACT_LSB    = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_WAVE = 3'h0;
  localparam logic [2:0] RESET_EVENT_ACTION_SELECT = 3'h0;

  typedef enum logic [1:0] {
    CMD_NONE       = 2'b00,
    CMD_UPDATE     = 2'b01,
    CMD_RESTART    = 2'b10,
    CMD_HARD_RESET = 2'b11
  } command_t;

  typedef enum logic [2:0] {
    EV_RISING = 3'b000,
    EV_ANY    = 3'b001,
    EV_HIGH   = 3'b010,
    EV_UPDOWN = 3'b011
  } event_action_t;

  // Waveform generation modes
  localparam logic [2:0] WAVE_NORMAL    = 3'h0;
  localparam logic [2:0] WAVE_FREQ      = 3'h1;
  localparam logic [2:0] WAVE_SINGLE    = 3'h3;
  localparam logic [2:0] WAVE_DS_TOP    = 3'h5;
  localparam logic [2:0] WAVE_DS_BOTH   = 3'h6;
  localparam logic [2:0] WAVE_DS_BOTTOM = 3'h7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic at_top;
    logic at_bottom;
    logic prescale_tick;
    logic event_level;
  } counter_status_t;

endpackage

// file: hdl/update_lock_ctrl.sv
module update_lock_ctrl #(
  parameter int NUM_CMP = timer_ctrl_pkg::NUM_CMP
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               hard_reset_i,
  input  wire logic               update_event_i,
  input  wire logic               auto_lock_i,
  input  wire logic [NUM_CMP-1:0] cmp_enable_i,
  input  wire logic               lock_set_i,
  input  wire logic               lock_clear_i,
  input  wire logic [NUM_CMP:0]   bv_set_i,
  input  wire logic [NUM_CMP:0]   bv_clear_i,
  input  wire logic [NUM_CMP:0]   buffer_write_i,
  output logic                    update_lock_o,
  output logic [NUM_CMP:0]        buffer_valid_o,
  output logic                    transfer_o
);

  typedef struct packed {
    logic             lock;
    logic [NUM_CMP:0] bv;
    logic             transfer;
  } lock_state_t;

  lock_state_t s;
  lock_state_t n;

  always_comb begin
    n = s;
    n.transfer = update_event_i & ~s.lock;
    n.bv = s.bv & ~bv_clear_i;
    if (n.transfer) begin
      n.bv = '0;
    end
    n.bv = n.bv | bv_set_i | buffer_write_i;
    n.lock = (s.lock & ~lock_clear_i) | lock_set_i;
    if (auto_lock_i) begin
      n.lock = ~(&(n.bv[NUM_CMP:1] | ~cmp_enable_i));
    end
    if (hard_reset_i) begin
      n = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign update_lock_o  = s.lock;
  assign buffer_valid_o = s.bv;
  assign transfer_o     = s.transfer;

endmodule

// file: verification/test_timer_control_update_regs.sv
module test_timer_control_update_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ECLR = timer_ctrl_pkg::OFF_CTRL_E_CLR;
  localparam logic [7:0] ESET = timer_ctrl_pkg::OFF_CTRL_E_SET;
  localparam logic [7:0] FCLR = timer_ctrl_pkg::OFF_BV_CLR;
  localparam logic [7:0] FSET = timer_ctrl_pkg::OFF_BV_SET;
  localparam logic [7:0] EV   = timer_ctrl_pkg::OFF_EVENT_CTRL;
  logic                            clock_i = 1'b0;
  logic                            rst_i = 1'b1;
  timer_ctrl_pkg::bus_req_t        bus_i = '0;
  timer_ctrl_pkg::counter_status_t status_i = '0;
  logic                            period_buffer_write_i = 1'b0;
  logic [2:0]                      compare_buffer_write_i = 3'h0;
  logic [7:0]                      rdata_o;
  logic [2:0]                      waveform_mode_select_o;
  logic                            enable_o, split_mode_enable_o, count_down_o, restart_o;
  logic                            hard_reset_o, transfer_o, update_lock_o, count_tick_o;
  int                              miscompares = 0;
  int                              n_checks = 0;
  int                              cycles = 0;

  timer_control_update_regs timer_control_update_regs_inst (
    .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .status_i(status_i),
    .period_buffer_write_i(period_buffer_write_i),
    .compare_buffer_write_i(compare_buffer_write_i), .rdata_o(rdata_o), .enable_o(enable_o),
    .split_mode_enable_o(split_mode_enable_o), .waveform_mode_select_o(waveform_mode_select_o),
    .count_down_o(count_down_o), .restart_o(restart_o), .hard_reset_o(hard_reset_o),
    .transfer_o(transfer_o), .update_lock_o(update_lock_o), .count_tick_o(count_tick_o)
  );

  always #5 clock_i = ~clock_i;

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Far longer than the sequence needs, so only a hang reaches it
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
    check(rdata_o, exp);
  endtask

  task automatic stat(input timer_ctrl_pkg::counter_status_t s);
    @(posedge clock_i);
    status_i <= s;
    @(posedge clock_i);
    status_i <= '0;
    #1;
  endtask

  task automatic bufw(input logic p, input logic [2:0] c);
    @(posedge clock_i);
    period_buffer_write_i <= p;
    compare_buffer_write_i <= c;
    @(posedge clock_i);
    period_buffer_write_i <= 1'b0;
    compare_buffer_write_i <= 3'h0;
    #1;
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(ECLR, 8'h00);
    rd(FSET, 8'h00);
    rd(EV, 8'h00);
    rd(8'h08, 8'h00);
    wr(ESET, 8'h03);
    check({7'h0, count_down_o}, 8'h01);
    rd(ECLR, 8'h03);
    wr(ECLR, 8'h01);
    check({6'h0, update_lock_o, count_down_o}, 8'h02);
    bufw(1'b1, 3'h0);
    rd(FCLR, 8'h01);
    bufw(1'b0, 3'h7);
    rd(FCLR, 8'h0F);
    wr(ESET, 8'h06);
    check({7'h0, transfer_o}, 8'h00);
    rd(ESET, 8'h02);
    stat(4'b1000);
    check({7'h0, transfer_o}, 8'h00);
    rd(FSET, 8'h0F);
    wr(ECLR, 8'h02);
    stat(4'b1000);
    check({7'h0, transfer_o}, 8'h01);
    rd(FSET, 8'h00);
    wr(FSET, 8'h05);
    rd(FCLR, 8'h05);
    wr(FCLR, 8'h01);
    rd(FSET, 8'h04);
    wr(ECLR, 8'h04);
    check({7'h0, transfer_o}, 8'h01);
    rd(FSET, 8'h00);
    wr(ESET, 8'h01);
    wr(ESET, 8'h08);
    check({6'h0, restart_o, count_down_o}, 8'h02);
    @(posedge clock_i);
    #1;
    check({7'h0, restart_o}, 8'h00);
    wr(ESET, 8'h02);
    wr(ESET, 8'h0C);
    check({7'h0, hard_reset_o}, 8'h01);
    rd(ESET, 8'h00);
    wr(timer_ctrl_pkg::OFF_ENABLE_CTRL, 8'h01);
    wr(ESET, 8'h0E);
    check({6'h0, enable_o, hard_reset_o}, 8'h02);
    rd(ESET, 8'h02);
    for (int a = 0; a < 4; a++) begin
      wr(EV, 8'(2 * a + 1));
      rd(EV, 8'(2 * a + 1));
    end
    @(posedge clock_i);
    status_i.event_level <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check({7'h0, count_down_o}, 8'h01);
    status_i.event_level <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check({7'h0, count_down_o}, 8'h00);
    stat(4'h2);
    check({7'h0, count_tick_o}, 8'h01);
    wr(EV, 8'h01);
    stat(4'h1);
    check({7'h0, count_tick_o}, 8'h01);
    @(posedge clock_i);
    #1;
    check({7'h0, count_tick_o}, 8'h00);
    wr(EV, 8'h03);
    stat(4'h1);
    check({7'h0, count_tick_o}, 8'h01);
    @(posedge clock_i);
    #1;
    check({7'h0, count_tick_o}, 8'h01);
    wr(EV, 8'h05);
    stat(4'h2);
    check({7'h0, count_tick_o}, 8'h00);
    stat(4'h3);
    check({7'h0, count_tick_o}, 8'h01);
    wr(EV, 8'h00);
    stat(4'h2);
    check({7'h0, count_tick_o}, 8'h01);
    wr(timer_ctrl_pkg::OFF_ENABLE_CTRL, 8'h00);
    stat(4'h2);
    check({7'h0, count_tick_o}, 8'h00);
    wr(ECLR, 8'h02);
    wr(timer_ctrl_pkg::OFF_MODE_CTRL, 8'h05);
    stat(4'b1000);
    check({6'h0, count_down_o, transfer_o}, 8'h02);
    stat(4'b0100);
    check({6'h0, count_down_o, transfer_o}, 8'h01);
    wr(timer_ctrl_pkg::OFF_MODE_CTRL, 8'h38);
    // Auto lock acts one cycle after the mode write lands
    @(posedge clock_i);
    #1;
    check({7'h0, update_lock_o}, 8'h01);
    bufw(1'b0, 3'h1);
    check({7'h0, update_lock_o}, 8'h01);
    bufw(1'b0, 3'h2);
    check({7'h0, update_lock_o}, 8'h00);
    stat(4'b1000);
    check({7'h0, transfer_o}, 8'h01);
    @(posedge clock_i);
    #1;
    check({7'h0, update_lock_o}, 8'h01);
    wr(timer_ctrl_pkg::OFF_MODE_CTRL, 8'h00);
    wr(timer_ctrl_pkg::OFF_SPLIT_CTRL, 8'h01);
    check({7'h0, split_mode_enable_o}, 8'h01);
    bufw(1'b1, 3'h0);
    rd(FCLR, 8'h00);
    wr(timer_ctrl_pkg::OFF_SPLIT_CTRL, 8'h00);
    rd(FCLR, 8'h00);
    check({7'h0, split_mode_enable_o}, 8'h00);
    end_of_test();
  end
endmodule

// file: verification/timer_regs_assertions.sv
module timer_regs_assertions (
  input wire logic                            clock_i,
  input wire logic                            rst_i,
  input wire timer_ctrl_pkg::bus_req_t        bus_i,
  input wire timer_ctrl_pkg::counter_status_t status_i,
  input wire logic [7:0]                      rdata_o,
  input wire logic                            enable_o,
  input wire logic                            split_mode_enable_o,
  input wire logic [2:0]                      waveform_mode_select_o,
  input wire logic                            count_down_o,
  input wire logic                            restart_o,
  input wire logic                            hard_reset_o,
  input wire logic                            transfer_o,
  input wire logic                            update_lock_o,
  input wire logic                            count_tick_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Split mode hides only the buffer valid view; only normal-mode writes to the 0x04/0x05 views are judged
  logic view_wr;
  assign view_wr = bus_i.wr && (bus_i.addr[7:1] == 7'h02) && !split_mode_enable_o;

  a_split_follow:
    assert property (bus_i.wr && bus_i.addr == 8'h03
      |=> split_mode_enable_o == $past(bus_i.wdata[0])) else $error("split bit not written");
  a_clear_view:
    assert property (view_wr && !bus_i.addr[0] && bus_i.wdata[0] |=> !count_down_o)
      else $error("clear view left direction set");
  a_set_view:
    assert property (view_wr && bus_i.addr[0] && bus_i.wdata[0] && !bus_i.wdata[3]
      |=> count_down_o) else $error("set view did not set direction");
  a_restart_pulse:
    assert property (view_wr && bus_i.wdata[3:2] == 2'b10
      |=> restart_o && !count_down_o ##1 !restart_o) else $error("restart pulse wrong");
  a_hard_reset_taken:
    assert property (view_wr && bus_i.wdata[3:2] == 2'b11 && !enable_o |=> hard_reset_o)
      else $error("hard reset not taken");
  a_hard_reset_gate:
    assert property (hard_reset_o |-> !$past(enable_o)) else $error("hard reset while enabled");
  a_lock_blocks:
    assert property (transfer_o |-> !$past(update_lock_o)) else $error("transfer while locked");
  a_top_update:
    assert property (!update_lock_o && status_i.at_top && !count_down_o && !split_mode_enable_o
      && waveform_mode_select_o inside {3'h0, 3'h1} |=> transfer_o)
      else $error("no transfer at top");
  a_bottom_update:
    assert property (!update_lock_o && status_i.at_bottom && !split_mode_enable_o
      && waveform_mode_select_o inside {3'h3, 3'h5, 3'h6, 3'h7} |=> transfer_o)
      else $error("no transfer at bottom");
  a_cmd_reads_zero:
    assert property (bus_i.rd && bus_i.addr[7:1] == 7'h02 |=> rdata_o[3:2] == 2'b00)
      else $error("command field read nonzero");
  a_tick_disabled:
    assert property (!enable_o |=> !count_tick_o) else $error("count tick while disabled");
endmodule

bind timer_control_update_regs timer_regs_assertions timer_regs_assertions_inst (
  .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .status_i(status_i), .rdata_o(rdata_o),
  .enable_o(enable_o), .split_mode_enable_o(split_mode_enable_o),
  .waveform_mode_select_o(waveform_mode_select_o), .count_down_o(count_down_o),
  .restart_o(restart_o), .hard_reset_o(hard_reset_o), .transfer_o(transfer_o),
  .update_lock_o(update_lock_o), .count_tick_o(count_tick_o)
);
